// >>> wsc_pkg.sv
// package of constants and types for the warp sequencer control block
package wsc_pkg;
	// ****************************************
	// timing and field widths
	// ****************************************
	localparam int unsigned   INIT_LAT      = 9;          // cycles from init release to first addr
	localparam logic [3:0]    INIT_LAT_CNT  = 4'h9;
	localparam int unsigned   DLY_W         = 3;          // delay field, 0..7
	localparam int unsigned   WALK_W        = 8;          // walk length counter width
	localparam int unsigned   POS_W         = 12;         // pixel / line counter width
	localparam int unsigned   TARGET_ADDRESS_W        = 12;         // target address width
	localparam logic [7:0]    WALK_RST      = 8'h00;
	localparam logic [11:0]   POS_RST       = 12'h000;
	localparam logic [3:0]    CNT_RST       = 4'h0;
	localparam logic [7:0]    PIPE_RST      = 8'hff;      // strobes idle high

	// ****************************************
	// sequencer states
	// ****************************************
	typedef enum logic [1:0] {
		WSC_IDLE  = 2'b00,
		WSC_PRIME = 2'b01,
		WSC_RUN   = 2'b10,
		WSC_HALT  = 2'b11
	} wsc_state_t;
endpackage : wsc_pkg

// >>> wsc_top.sv
// control and strobe logic of the warp address sequencer
// Notes on behaviour
// - init high clears control, loads working params
// - first address nine clocks after init low
// - run high at end restarts without gap
// - run low at end halts, params at last line
// - halted strobe and address outputs hold until run sampled high
// - select high blocks preload strobe next clock
// - restart strobe low first walk cycle
// - nearest neighbour keeps both strobes low
// - restart strobe delayed zero to seven clocks
// - write strobe low last walk cycle
// - write strobe delayed zero to seven clocks
// - stall low freezes transform two clocks later
// - preload writes continue while stalled
// - target outputs driven only while enable low
`timescale 1ns/1ps
module wsc_top (
	// clock and reset
	input  wire logic                      clk,
	input  wire logic                      nrst,
	// control pins
	input  wire logic                      init,
	input  wire logic                      run,
	input  wire logic                      stall_n,
	input  wire logic                      param_select_n,
	input  wire logic                      host_write_n,
	input  wire logic                      target_port_enable_n,
	// transform configuration from the preload side
	input  wire logic                      nearest_mode,
	input  wire logic [wsc_pkg::WALK_W-1:0] walk_len,
	input  wire logic [wsc_pkg::POS_W-1:0]  line_len,
	input  wire logic [wsc_pkg::POS_W-1:0]  line_cnt,
	input  wire logic [wsc_pkg::DLY_W-1:0]  mac_restart_delay,
	input  wire logic [wsc_pkg::DLY_W-1:0]  target_write_delay,
	// outputs
	output logic                           param_write_strobe,
	output logic                           param_transfer,
	output logic                           first_address,
	output logic                           running,
	output logic                           mac_restart_n,
	output logic                           target_write_n_o,
	output logic                           target_write_n_oe,
	output logic [wsc_pkg::TARGET_ADDRESS_W-1:0]     target_address_o,
	output logic                           target_address_oe
);
	import wsc_pkg::*;

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [5:0] sync1_q;
	logic [5:0] sync2_q;
	// two stages on every pin input; the pins arrive from the host board with no
	// relation to clk, so nothing but the second stage is read by the logic
	// reset loads the idle level of each pin: init low, the rest high, so that
	// no false select, stall or output enable is seen in the first cycles
	always_ff @(posedge clk) begin
		if (!nrst) begin
			sync1_q <= 6'h3e;
			sync2_q <= 6'h3e;
		end else begin
			sync1_q <= {host_write_n, target_port_enable_n, param_select_n, stall_n, run, init};
			sync2_q <= sync1_q;
		end
	end
	logic init_s, run_s, stall_s, sel_s, oe_s, wr_s;
	assign {wr_s, oe_s, sel_s, stall_s, run_s, init_s} = sync2_q;

	// ****************************************
	// preload strobe gating
	// ****************************************
	// select high blocks the strobe on the next clock; stall does not gate it
	// the strobe follows the host write, so a frozen frame can still be reloaded
	always_ff @(posedge clk) begin
		if (!nrst) param_write_strobe <= 1'b0;
		else       param_write_strobe <= !sel_s && !wr_s;
	end

	// ****************************************
	// clock stall
	// ****************************************
	logic adv_q;
	// internal advance drops one clock after stall sampled low
	// init forces the advance on so that the delay pipes keep shifting during init while stalled;
	// the extra stage keeps the freeze aligned with the registered pin
	always_ff @(posedge clk) begin
		if (!nrst) adv_q <= 1'b1;
		else       adv_q <= stall_s || init_s;
	end

	// ****************************************
	// sequencer
	// ****************************************
	wsc_state_t          state_q;
	logic [3:0]          lat_q;
	logic [WALK_W-1:0]   walk_q;
	logic [POS_W-1:0]    pix_q;
	logic [POS_W-1:0]    line_q;
	logic                walk_first, walk_last, line_end, frame_end, last_line;

	// a size of zero counts as one, so a cleared size input cannot hang the counters
	function automatic logic at_end(input logic [POS_W-1:0] v, input logic [POS_W-1:0] lim);
		at_end = (v == lim - POS_W'(1)) || (lim == POS_RST);
	endfunction : at_end

	assign walk_first = (walk_q == WALK_RST);
	assign walk_last  = (walk_q == walk_len - WALK_W'(1)) || (walk_len == WALK_RST);
	assign line_end   = walk_last && at_end(pix_q, line_len);
	assign last_line  = at_end(line_q, line_cnt);
	assign frame_end  = line_end && last_line;

	// state, latency and position counters
	// init wins over run and stall here because its branch comes first
	// walks, pixels and lines move only while the internal advance is on
	always_ff @(posedge clk) begin
		if (!nrst) begin
			state_q <= WSC_IDLE;
			lat_q   <= CNT_RST;
			walk_q  <= WALK_RST;
			pix_q   <= POS_RST;
			line_q  <= POS_RST;
		end else if (init_s) begin
			state_q <= WSC_PRIME;
			lat_q   <= CNT_RST;
			walk_q  <= WALK_RST;
			pix_q   <= POS_RST;
			line_q  <= POS_RST;
		end else if (adv_q) begin
			case (state_q)
				WSC_IDLE: begin
					state_q <= WSC_IDLE;
				end
				WSC_PRIME: begin
					lat_q <= lat_q + 4'h1;
					if (lat_q == INIT_LAT_CNT - 4'h2) state_q <= WSC_RUN;
				end
				WSC_RUN: begin
					walk_q <= walk_last ? WALK_RST : walk_q + WALK_W'(1);
					if (line_end) begin
						pix_q  <= POS_RST;
						line_q <= last_line ? POS_RST : line_q + POS_W'(1);
					end else if (walk_last) begin
						pix_q <= pix_q + POS_W'(1);
					end
					if (frame_end && !run_s) state_q <= WSC_HALT;
					// otherwise stay in run, next frame follows at once
				end
				WSC_HALT: begin
					if (run_s) state_q <= WSC_RUN;
				end
				default: state_q <= WSC_IDLE;
			endcase
		end
	end

	logic act;
	assign act = (state_q == WSC_RUN) && adv_q && !init_s;

	// status outputs
	// each stands in the cycle after its cause; param_transfer stays high while init is held, running is a level
	always_ff @(posedge clk) begin
		if (!nrst) begin
			param_transfer <= 1'b0;
			first_address  <= 1'b0;
			running        <= 1'b0;
		end else begin
			// working registers load on init and on first clock of last line
			param_transfer <= init_s || (act && line_end && at_end(line_q + POS_W'(1), line_cnt)
				&& !last_line) || (act && frame_end && line_cnt == POS_W'(1));
			first_address  <= (state_q == WSC_PRIME) && adv_q && !init_s
				&& lat_q == INIT_LAT_CNT - 4'h2;
			running        <= state_q == WSC_RUN;
		end
	end

	// ****************************************
	// strobes with delay pipes
	// ****************************************
	logic       mac_nom, twr_nom;
	logic [7:0] mac_pipe_q, twr_pipe_q;
	logic [TARGET_ADDRESS_W-1:0] target_address_q;
	// nominal strobes; idle when not advancing unless nearest_mode holds them low, only the delay pipes hold
	// both strobes idle high; the delay pipes shift only while the sequence advances,
	// so a stall or a halt freezes them together with the walk they belong to
	assign mac_nom = nearest_mode ? 1'b0 : !(act && walk_first);
	assign twr_nom = nearest_mode ? 1'b0 : !(act && walk_last);

	always_ff @(posedge clk) begin
		if (!nrst) begin
			mac_pipe_q <= PIPE_RST;
			twr_pipe_q <= PIPE_RST;
			target_address_q     <= POS_RST;
		end else if (adv_q && state_q != WSC_HALT) begin
			mac_pipe_q <= {mac_pipe_q[6:0], mac_nom};
			twr_pipe_q <= {twr_pipe_q[6:0], twr_nom};
			if (act && walk_last) target_address_q <= pix_q;
		end
	end

	// delayed outputs and target port enables
	// the tap of each pipe picks the programmed delay; the enables follow the
	// synchronised enable pin, high while the block drives the target port
	always_ff @(posedge clk) begin
		if (!nrst) begin
			mac_restart_n     <= 1'b1;
			target_write_n_o  <= 1'b1;
			target_write_n_oe <= 1'b0;
			target_address_o  <= POS_RST;
			target_address_oe <= 1'b0;
		end else begin
			mac_restart_n     <= mac_pipe_q[mac_restart_delay];
			target_write_n_o  <= twr_pipe_q[target_write_delay];
			target_write_n_oe <= !oe_s;
			target_address_o  <= target_address_q;
			target_address_oe <= !oe_s;
		end
	end
endmodule : wsc_top

// >>> wsc_chk_sva.sv
// port assertions for the warp sequencer control block
`timescale 1ns/1ps
module wsc_chk (
	// clock and reset
	input wire logic        clk,
	input wire logic        nrst,
	// control pins
	input wire logic        init,
	input wire logic        stall_n,
	input wire logic        param_select_n,
	input wire logic        host_write_n,
	input wire logic        target_port_enable_n,
	// outputs
	input wire logic        param_write_strobe,
	input wire logic        param_transfer,
	input wire logic        first_address,
	input wire logic        running,
	input wire logic        mac_restart_n,
	input wire logic [11:0] target_address_o,
	input wire logic        target_write_n_oe,
	input wire logic        target_address_oe
);
	// ****
	// pins reach the logic three clocks after they are sampled
	// ****
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	// init released and held low with the clock running
	sequence s_release;
		$fell(init) ##1 (!init && stall_n) [*8];
	endsequence
	chk_oe_off: assert property (target_port_enable_n [*5] |->
		!target_write_n_oe && !target_address_oe) else $error("target port on while off");
	chk_oe_on: assert property (!target_port_enable_n [*5] |->
		target_write_n_oe && target_address_oe) else $error("target port off while on");
	chk_sel_block: assert property (param_select_n [*4] |-> !param_write_strobe)
		else $error("preload strobe passed while blocked");
	chk_sel_open: assert property ((!param_select_n && !host_write_n) [*5] |->
		param_write_strobe) else $error("preload strobe missing");
	chk_init_late: assert property (s_release |-> ##[1:5] first_address)
		else $error("first address late");
	chk_init_early: assert property ($fell(init) |-> !first_address [*8])
		else $error("first address early");
	chk_init_prio: assert property (init [*5] |-> !running && !first_address)
		else $error("sequencer ran during init");
	chk_init_load: assert property (init [*4] |-> param_transfer)
		else $error("working registers not loaded on init");
	chk_stall_hold: assert property ((!stall_n && !init) [*5] |=>
		$stable(target_address_o) && $stable(mac_restart_n)) else $error("moved while stalled");
endmodule : wsc_chk
bind wsc_top wsc_chk u_chk (.clk, .nrst, .init, .stall_n, .param_select_n, .host_write_n,
	.target_port_enable_n, .param_write_strobe, .param_transfer, .first_address, .running,
	.mac_restart_n,
	.target_address_o, .target_write_n_oe, .target_address_oe);

// >>> wsc_host.sv
// host model that drives the preload write line
`timescale 1ns/1ps
module wsc_host (
	// clock and command
	input  wire logic clk,
	input  wire logic go,
	// preload write towards the block
	output logic      host_write_n
);
	logic [2:0] left_q = 3'h0;
	// each command holds the write low six clocks, only when the bench asks
	always_ff @(posedge clk) begin
		if (go) begin
			left_q <= 3'h6;
		end else if (left_q != 3'h0) begin
			left_q <= left_q - 3'h1;
		end
	end
	assign host_write_n = (left_q == 3'h0);
endmodule : wsc_host

// >>> warp_sequencer_control_tb.sv
// self-checking bench for the warp sequencer control block
`timescale 1ns/1ps
module warp_sequencer_control_tb;
	// ****
	// stimulus and bookkeeping
	// ****
	logic clk = 1'h0, nrst = 1'h0, init = 1'h0, run = 1'h0, stall_n = 1'h1, go = 1'h0;
	logic param_select_n = 1'h0, target_port_enable_n = 1'h0, nearest_mode = 1'h0;
	logic [7:0] walk_len = 8'h02;
	logic [11:0] line_len = 12'h002, line_cnt = 12'h002, target_address_o;
	logic [2:0] mac_restart_delay = 3'h0, target_write_delay = 3'h0;
	logic host_write_n, param_write_strobe, first_address, running, mac_restart_n;
	logic target_write_n_o, target_write_n_oe, target_address_oe;
	logic [5:0] q_m[$], q_v[$];
	int n_mismatch = 0, cmp_count = 0;
	int t_mac = 99, t_twr = 99, c_mac = 0, c_twr = 0;
	integer seed = 32'h0000_a113;
	wire [5:0] obs = {running, param_write_strobe, target_write_n_oe, target_address_oe,
		mac_restart_n, target_write_n_o};
	always #5 clk = ~clk;
	wsc_host host (.clk, .go, .host_write_n);
	wsc_top dut (.clk, .nrst, .init, .run, .stall_n, .param_select_n, .host_write_n,
		.target_port_enable_n, .nearest_mode, .walk_len, .line_len, .line_cnt,
		.mac_restart_delay, .target_write_delay, .param_write_strobe, .param_transfer(),
		.first_address, .running, .mac_restart_n, .target_write_n_o, .target_write_n_oe,
		.target_address_o, .target_address_oe);
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	task automatic note(input logic [5:0] m, input logic [5:0] v);
		q_m.push_back(m);
		q_v.push_back(v & m);
	endtask : note
	task automatic wait_run(input logic want);
		for (int i = 0; i < 500 && running !== want; i++) @(negedge clk);
		@(posedge clk);
	endtask : wait_run
	task automatic check(input logic [5:0] seen, input logic [5:0] want);
		cmp_count++;
		if (seen !== want) begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : check
	task automatic close_out();
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : close_out
	// the oldest note is compared once the outputs have settled
	always @(negedge clk) begin
		if (q_m.size() > 0) begin
			check(obs & q_m[0], q_v[0]);
			void'(q_m.pop_front());
			void'(q_v.pop_front());
		end
	end
	// reset, init with random walk and delays, then each control in turn
	initial begin
		cyc(2);
		note(6'h2f, 6'h03);
		cyc(1);
		nrst <= 1'h1;
		init <= 1'h1;
		run <= 1'h1;
		walk_len <= 8'h02 + (8'($random(seed)) & 8'h07);
		mac_restart_delay <= 3'($random(seed));
		target_write_delay <= 3'($random(seed));
		cyc(6);
		note(6'h20, 6'h00);
		init <= 1'h0;
		// first restart and first write strobe, counted from the first address cycle
		for (int i = 0; i < 40 && first_address !== 1'h1; i++) @(negedge clk);
		for (int i = 0; i < 20; i++) begin
			if (mac_restart_n === 1'h0 && t_mac == 99) t_mac = i;
			if (target_write_n_o === 1'h0 && t_twr == 99) t_twr = i;
			@(negedge clk);
		end
		check(6'(t_mac), 6'(mac_restart_delay) + 6'h02);
		check(6'(t_twr), 6'(walk_len) + 6'(target_write_delay) + 6'h01);
		wait_run(1'h1);
		note(6'h20, 6'h20);
		target_port_enable_n <= 1'h1;
		cyc(6);
		note(6'h0c, 6'h00);
		target_port_enable_n <= 1'h0;
		stall_n <= 1'h0;
		for (int k = 0; k < 2; k++) begin
			param_select_n <= 1'(k);
			go <= 1'h1;
			cyc(1);
			go <= 1'h0;
			cyc(5);
			note(6'h1c, k ? 6'h0c : 6'h1c);
		end
		param_select_n <= 1'h0;
		stall_n <= 1'h1;
		run <= 1'h0;
		wait_run(1'h0);
		cyc(20);
		note(6'h20, 6'h00);
		run <= 1'h1;
		cyc(5);
		note(6'h20, 6'h20);
		init <= 1'h1;
		nearest_mode <= 1'h1;
		cyc(6);
		init <= 1'h0;
		wait_run(1'h1);
		cyc(12);
		note(6'h23, 6'h20);
		nearest_mode <= 1'h0;
		cyc(20);
		// steady run: any two walks hold exactly one restart and one write each
		repeat (2 * walk_len) begin
			@(negedge clk);
			c_mac += (mac_restart_n === 1'h0);
			c_twr += (target_write_n_o === 1'h0);
		end
		check(6'(c_mac), 6'h02);
		check(6'(c_twr), 6'h02);
		check({5'h00, target_address_o < line_len}, 6'h01);
		cyc(180);
		note(6'h20, 6'h20);
		cyc(2);
		close_out();
	end
	// watchdog well beyond the expected run length
	initial begin
		#50000;
		n_mismatch++;
		close_out();
	end
endmodule : warp_sequencer_control_tb
